// ===== shared/wws_pkg.sv
// Timing constants and shared types for the windowed watchdog supervisor
package wws_pkg;
  localparam int unsigned CNT_W            = 32;
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned GLITCH_NS        = 100;
  localparam int unsigned FAULT_PULSE_NS   = 1000000;
  localparam int unsigned RESET_TIMEOUT_NS = 100000000;
  localparam int unsigned FAST_LIMIT_NS    = 10000000;
  localparam int unsigned SLOW_LIMIT_NS    = 100000000;
  // Filter length is one cycle beyond the longest glitch to reject
  localparam logic [7:0]  GLITCH_CYC =
    8'((GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
  localparam logic [31:0] FAULT_CYC  = 32'(FAULT_PULSE_NS / CLK_PERIOD_NS);
  localparam logic [31:0] RESET_CYC  =
    32'((RESET_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] FAST_CYC   = 32'(FAST_LIMIT_NS / CLK_PERIOD_NS);
  localparam logic [31:0] SLOW_CYC   = 32'(SLOW_LIMIT_NS / CLK_PERIOD_NS);
  localparam logic        IDLE_HIGH  = 1'b1;

  typedef enum logic [1:0] {WWS_FIRST, WWS_WATCH, WWS_FAULT} wws_mode_t;
endpackage

// ===== core/wws_filter.sv
// Two-flop synchroniser followed by a stable-level glitch filter
`timescale 1ns/10ps
`default_nettype none
module wws_filter
  import wws_pkg::*;
#(
  parameter logic [7:0] FILT_CYC  = GLITCH_CYC,
  parameter logic       RESET_VAL = IDLE_HIGH
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Raw pin and filtered level
  input  wire logic raw_i,
  output var  logic level_o
);
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       level;
    logic [7:0] cnt;
  } wws_filt_t;

  wws_filt_t q;
  wws_filt_t d;

  always_comb begin
    d     = q;
    d.s1  = raw_i;
    d.s2  = q.s1;
    if (q.s2 == q.level) begin
      d.cnt = 8'h00;
    end else if (q.cnt == FILT_CYC - 8'h01) begin
      d.level = q.s2;
      d.cnt   = 8'h00;
    end else begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= '{s1: RESET_VAL, s2: RESET_VAL, level: RESET_VAL, cnt: 8'h00};
    end else begin
      q <= d;
    end
  end

  assign level_o = q.level;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_filter_settle: assert property (
    q.level != $past(q.level) |-> $past(q.cnt) == FILT_CYC - 8'h01
  ) else $error("filtered level changed before input was stable");
endmodule
`default_nettype wire

// ===== core/wws_supervisor.sv
// Windowed watchdog with fault pulse and supply/manual reset generator
// Overview of operation
// - Manual reset low: reset, clear counter, release fault
// - Kick falling edge restarts counter outside reset
// - In-window edge quiet; early/late edge pulses fault
// - Edges closer than fast limit raise fault
// - No edge before slow limit raises fault
// - Counter cleared on valid edge, reset/fault end
// - Kick input ignored during reset or fault
// - First edge after reset/fault never fast fault
// - Fault output inactive whenever reset asserted
// - Watchdog fault never asserts reset by itself
// - Reset while supply bad or manual reset low
// - Reset held timeout after causes clear
// - Manual reset glitches filtered; fault pulse one millisecond
`timescale 1ns/10ps
`default_nettype none
module wws_supervisor
  import wws_pkg::*;
#(
  parameter logic [31:0] FAST_LIMIT_CYC = FAST_CYC,
  parameter logic [31:0] SLOW_LIMIT_CYC = SLOW_CYC,
  parameter logic [31:0] FAULT_PULSE_CYC = FAULT_CYC,
  parameter logic [31:0] RESET_TIMEOUT_CYC = RESET_CYC
) (
  // Clock and power-on reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Supply monitor and manual reset
  input  wire logic supply_good_i,
  input  wire logic manual_reset_n_i,
  // Watchdog kick from the processor
  input  wire logic watchdog_kick_in_i,
  // Reset output, active low
  output var  logic reset_n_o,
  // Open-drain fault pulse, active low
  input  wire logic fault_pulse_out_n_i,
  output var  logic fault_pulse_out_n_o,
  output var  logic fault_pulse_out_n_oe_o
);
  typedef struct packed {
    logic             rst_active;
    logic [CNT_W-1:0] rst_cnt;
    wws_mode_t        mode;
    logic [CNT_W-1:0] wd_cnt;
    logic [CNT_W-1:0] fault_cnt;
    logic             kick_prev;
  } wws_state_t;

  wws_state_t q;
  wws_state_t d;
  logic       manual_level;
  logic       kick_level;
  logic       rst_cause;
  logic       live;
  logic       fall;
  logic       fast_fault;
  logic       slow_fault;
  logic       accept;

  wws_filter #(
    .FILT_CYC  (GLITCH_CYC),
    .RESET_VAL (IDLE_HIGH)
  ) u_manual_filter (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .raw_i   (manual_reset_n_i),
    .level_o (manual_level)
  );

  // Same filter on the kick pin keeps 100 ns spikes from counting as edges
  wws_filter #(
    .FILT_CYC  (GLITCH_CYC),
    .RESET_VAL (IDLE_HIGH)
  ) u_kick_filter (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .raw_i   (watchdog_kick_in_i),
    .level_o (kick_level)
  );

  assign rst_cause  = !supply_good_i || !manual_level;
  assign live       = !rst_cause && !q.rst_active;
  assign fall       = q.kick_prev && !kick_level;
  assign fast_fault = live && fall && q.mode == WWS_WATCH
                      && q.wd_cnt < FAST_LIMIT_CYC;
  assign slow_fault = live && !fall && q.mode != WWS_FAULT
                      && q.wd_cnt == SLOW_LIMIT_CYC - 32'h1;
  assign accept     = live && fall && q.mode != WWS_FAULT && !fast_fault;

  always_comb begin
    d           = q;
    d.kick_prev = kick_level;
    // Reset generator; the watchdog has no path into it
    if (rst_cause) begin
      d.rst_active = 1'b1;
      d.rst_cnt    = '0;
    end else if (q.rst_active) begin
      if (q.rst_cnt == RESET_TIMEOUT_CYC - 32'h1) begin
        d.rst_active = 1'b0;
        d.rst_cnt    = '0;
      end else begin
        d.rst_cnt = q.rst_cnt + 32'h1;
      end
    end
    // Watchdog held idle across the same edge that enters reset
    if (!live) begin
      d.mode      = WWS_FIRST;
      d.wd_cnt    = '0;
      d.fault_cnt = '0;
    end else begin
      case (q.mode)
        WWS_FIRST, WWS_WATCH: begin
          if (fast_fault || slow_fault) begin
            d.mode      = WWS_FAULT;
            d.fault_cnt = '0;
          end else if (accept) begin
            d.mode   = WWS_WATCH;
            d.wd_cnt = '0;
          end else begin
            d.wd_cnt = q.wd_cnt + 32'h1;
          end
        end
        WWS_FAULT: begin
          // Kick edges fall through here unused
          if (q.fault_cnt == FAULT_PULSE_CYC - 32'h1) begin
            d.mode      = WWS_FIRST;
            d.wd_cnt    = '0;
            d.fault_cnt = '0;
          end else begin
            d.fault_cnt = q.fault_cnt + 32'h1;
          end
        end
        default: begin
          d.mode = WWS_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= '{rst_active: 1'b1, rst_cnt: '0, mode: WWS_FIRST, wd_cnt: '0,
             fault_cnt: '0, kick_prev: IDLE_HIGH};
    end else begin
      q <= d;
    end
  end

  assign reset_n_o              = !q.rst_active;
  // Pin only ever pulls low; level readback is not needed
  assign fault_pulse_out_n_o    = 1'b0;
  assign fault_pulse_out_n_oe_o = q.mode == WWS_FAULT;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_manual_holds_idle: assert property (
    !manual_level |=> !reset_n_o && !fault_pulse_out_n_oe_o && q.wd_cnt == '0
  ) else $error("manual reset did not hold reset and clear watchdog");
  a_edge_restarts: assert property (
    accept |=> q.wd_cnt == '0 ##1 q.wd_cnt == 32'h1 || !reset_n_o
               || fault_pulse_out_n_oe_o
  ) else $error("accepted edge did not restart the counter");
  a_pulse_width: assert property (
    fault_pulse_out_n_oe_o && q.fault_cnt != FAULT_PULSE_CYC - 32'h1 && live
    |=> fault_pulse_out_n_oe_o
  ) else $error("fault pulse ended early");
  a_fast_pulse: assert property (
    fast_fault |=> fault_pulse_out_n_oe_o && q.fault_cnt == '0
  ) else $error("early edge did not start fault pulse");
  a_slow_pulse: assert property (
    slow_fault |=> fault_pulse_out_n_oe_o
  ) else $error("missing edge did not start fault pulse");
  a_fault_end_clear: assert property (
    $fell(fault_pulse_out_n_oe_o) |-> q.wd_cnt == '0 && q.mode == WWS_FIRST
  ) else $error("counter not cleared at end of fault pulse");
  a_ignore_kick: assert property (
    fault_pulse_out_n_oe_o && $past(fault_pulse_out_n_oe_o) |-> $stable(q.wd_cnt)
  ) else $error("kick input acted during fault pulse");
  a_first_not_fast: assert property (
    q.mode == WWS_FIRST && fall && live |=> !fault_pulse_out_n_oe_o
  ) else $error("first edge after reset or fault raised fast fault");
  a_fault_in_reset: assert property (
    !reset_n_o |-> !fault_pulse_out_n_oe_o
  ) else $error("fault output active during reset");
  a_fault_no_reset: assert property (
    $rose(fault_pulse_out_n_oe_o) && supply_good_i && manual_level |-> reset_n_o
  ) else $error("fault pulse asserted reset");
  a_supply_reset: assert property (
    !supply_good_i |=> !reset_n_o
  ) else $error("supply low without reset");
  a_reset_timeout: assert property (
    $rose(reset_n_o) |-> $past(q.rst_cnt) == RESET_TIMEOUT_CYC - 32'h1
  ) else $error("reset released before timeout");

  c_fast_fault: cover property (fast_fault);
  c_slow_fault: cover property (slow_fault);
  c_window_edge: cover property (accept && q.mode == WWS_WATCH);
  c_reset_release: cover property ($rose(reset_n_o));
endmodule
`default_nettype wire

// ===== sim/wws_cpu_model.sv
// Processor model toggling the watchdog kick
`timescale 1ns/10ps
`default_nettype none
module wws_cpu_model (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  // Kick to the supervisor
  output var  logic       kick_o
);
  int         cnt    = 0;
  logic       run_q  = 1'h0;
  logic [7:0] half_q = 8'h06;
  int         lim;
  initial kick_o = 1'h1;
  // Controls taken on the rising edge so the falling-edge update never races the bench
  always @(posedge clk_i) begin
    run_q  <= run_i;
    half_q <= half_i;
  end
  assign lim = (half_q < 8'h06) ? 6 : int'(half_q);
  // Every level lasts at least 6 cycles, stopping too, so pulses stay 300 ns wide
  always @(negedge clk_i) begin
    if (cnt + 1 < lim) begin
      cnt <= cnt + 1;
    end else if (run_q || !kick_o) begin
      kick_o <= ~kick_o;
      cnt    <= 0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/windowed_watchdog_supervisor_bench.sv
// Self-checking bench for the windowed watchdog supervisor
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_supervisor_bench;
  import wws_pkg::*;
  localparam int FC = 20, SC = 100, PC = 10, RC = 30;
  logic       clk_i = 0, reset_i = 1, sup = 1, manual_n = 1, run = 0;
  logic [7:0] half = 8'h14;
  logic       kick, rst_n, oe, pin_o;
  int         failures = 0, n_checks = 0, n, k;
  int unsigned rng = 11404;
  always #25 clk_i = ~clk_i;
  wws_cpu_model cpu (.clk_i(clk_i), .run_i(run), .half_i(half), .kick_o(kick));
  wws_supervisor #(.FAST_LIMIT_CYC(32'(FC)), .SLOW_LIMIT_CYC(32'(SC)),
    .FAULT_PULSE_CYC(32'(PC)), .RESET_TIMEOUT_CYC(32'(RC))) uut (
    .clk_i(clk_i), .reset_i(reset_i), .supply_good_i(sup),
    .manual_reset_n_i(manual_n), .watchdog_kick_in_i(kick), .reset_n_o(rst_n),
    .fault_pulse_out_n_i(oe ? pin_o : 1'h1), .fault_pulse_out_n_o(pin_o),
    .fault_pulse_out_n_oe_o(oe));
  function automatic int unsigned xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // Held-low samples after a cause clears: input lag plus the full timeout
  function automatic logic [31:0] hold_ok(int seen, int lag);
    return 32'(seen >= RC + lag && seen <= RC + lag + 3);
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Counts cycles of low reset and of fault over a span, the current cycle first
  task automatic watch(int cyc);
    n = 0;
    k = 0;
    repeat (cyc) begin
      n += int'(rst_n === 1'h0);
      k += int'(oe === 1'h1);
      @(negedge clk_i);
    end
  endtask
  task automatic wait_oe(int lim);
    n = 0;
    while (oe !== 1'h1 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(4000 * 50);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(negedge clk_i);
    reset_i = 0;
    watch(RC + 10);
    check("boot_hold", hold_ok(n, 0), 1);
    check("boot_fault", 32'(k), 0);
    half = 8'(15 + xs() % 20);
    run = 1;
    watch(400);
    check("in_window", 32'(k), 0);
    half = 8'h06;
    wait_oe(60);
    // Kicks stop so no stray edge follows the pulse
    run = 0;
    check("fast_seen", 32'(oe), 1);
    check("pin_low", 32'(oe ? pin_o : 1'h1), 0);
    watch(PC + 2);
    check("pulse_len", 32'(k), PC);
    check("no_reset", 32'(n), 0);
    // One lone edge soon after the pulse must not count as fast
    run = 1;
    repeat (8) @(negedge clk_i);
    run = 0;
    wait_oe(SC + 40);
    check("slow_at", 32'(n > SC - 10 && n < SC + 10), 1);
    sup = 0;
    repeat (2) @(negedge clk_i);
    check("sup_reset", 32'(rst_n), 0);
    check("sup_cut", 32'(oe), 0);
    repeat (3) @(negedge clk_i);
    sup = 1;
    watch(RC + 10);
    check("sup_hold", hold_ok(n, 0), 1);
    check("sup_fault", 32'(k), 0);
    manual_n = 0;
    repeat (1 + xs() % 2) @(negedge clk_i);
    manual_n = 1;
    watch(15);
    check("glitch", 32'(n), 0);
    // Let a slow fault start, then cut it with a held manual reset
    wait_oe(SC + 40);
    check("slow_again", 32'(oe), 1);
    manual_n = 0;
    watch(20);
    check("manual_reset", 32'(n >= 12), 1);
    // Pulse stands until the filtered low lands: 2 sync, 3 filter, 1 register
    check("manual_fault", 32'(k), 6);
    manual_n = 1;
    watch(RC + 12);
    check("manual_hold", hold_ok(n, 5), 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
